// ---- hw/pcc_config_regs.sv ----
// Behaviour
// RQ1: bit 20 mirrors power-management control bit 19
// RQ2: syserr enable bit 8 drives SERR on address parity
// RQ3: parity response off ignores all parity errors
// RQ4: parity response on sets system error status
// RQ5: bus-master enable bit 2, resets to one
// RQ6: memory-space enable bit 1, resets to one
// RQ7: io control bit 0 inverted sense, resets one
// RQ8: class 02h and subclass 00h read-only
// RQ9: revision and step fields read-only
// RQ10: reserved bits read zero, writes ignored
module pcc_config_regs #(
   parameter logic [3:0] REVISION_NUMBER = 4'h0,  // Arbitrary value.
   parameter logic [3:0] STEP_NUMBER     = 4'h0   // Arbitrary value.
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [31:0]               power_mgmt_control_reg,
   input  wire pcc_pkg::pcc_parity_type   parity_in,
   output pcc_pkg::pcc_enables_type       enables,
   output logic                           serr_n_out,
   output logic                           serr_n_oe,
   output logic                           irq
);

   // ---------------------------------------------------------------
   // Storage.
   // ---------------------------------------------------------------
   logic                            syserr_response_enable;
   logic                            parity_response_enable;
   logic                            bus_master_enable;
   logic                            memory_space_enable;
   logic                            io_space_control;
   logic                            syserr_status;
   logic [pcc_pkg::IRQ_WIDTH-1:0]   irq_status;
   logic [pcc_pkg::IRQ_WIDTH-1:0]   irq_mask;
   logic [15:0]                     event_count;

   logic                            setup_phase;
   logic                            wr_strobe;
   logic                            clr_syserr;
   logic                            addr_err_taken;
   logic                            any_err_taken;
   logic [pcc_pkg::IRQ_WIDTH-1:0]   irq_events;
   logic [31:0]                     command_word;
   logic [31:0]                     class_word;
   logic [31:0]                     next_prdata;
   logic                            next_pslverr;
   logic                            addr_mapped;

   // The event counter holds at its top value instead of wrapping.
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;

   // ---------------------------------------------------------------
   // Bus decode.
   // ---------------------------------------------------------------

   // The slave answers in the first access cycle, so pready rises one
   // edge after the setup cycle and the write lands on the edge that ends that access cycle.
   assign setup_phase = psel & ~penable;
   assign wr_strobe   = psel & penable & pready & pwrite & ~pslverr;

   // Flags whether the address hits a register; an unmapped place is
   // answered with an error and leaves every piece of state alone.
   always_comb
   begin
      addr_mapped = 1'b1;
      if (paddr == pcc_pkg::ADDR_COMMAND)
      begin
         addr_mapped = 1'b1;
      end
      else if (paddr == pcc_pkg::ADDR_CLASS_REV)
      begin
         addr_mapped = 1'b1;
      end
      else if (paddr == pcc_pkg::ADDR_IRQ_STATUS)
      begin
         addr_mapped = 1'b1;
      end
      else if (paddr == pcc_pkg::ADDR_IRQ_MASK)
      begin
         addr_mapped = 1'b1;
      end
      else if (paddr == pcc_pkg::ADDR_EVENT_COUNT)
      begin
         addr_mapped = 1'b1;
      end
      else
      begin
         addr_mapped = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Parity handling.
   // ---------------------------------------------------------------

   // With the parity response off every error is dropped here, so no
   // status, SERR pulse or interrupt can follow from it.
   assign addr_err_taken = parity_in.addr_parity_error & parity_response_enable;   // [RQ3]
   assign any_err_taken  = (parity_in.addr_parity_error | parity_in.data_parity_error)
                           & parity_response_enable;                                // [RQ3]
   assign irq_events     = {parity_in.data_parity_error & parity_response_enable,
                            addr_err_taken};

   // Word assembly; reserved positions stay zero.
   always_comb
   begin
      command_word = pcc_pkg::ZERO_WORD;                                           // [RQ10]
      command_word[pcc_pkg::BIT_NEW_CAPS] = power_mgmt_control_reg[pcc_pkg::BIT_PM_CAPS]; // [RQ1]
      command_word[pcc_pkg::BIT_SYSERR_STATUS] = syserr_status;
      command_word[pcc_pkg::BIT_SYSERR_RESP]   = syserr_response_enable;
      command_word[pcc_pkg::BIT_PARITY_RESP]   = parity_response_enable;
      command_word[pcc_pkg::BIT_BUS_MASTER]    = bus_master_enable;
      command_word[pcc_pkg::BIT_MEM_SPACE]     = memory_space_enable;
      command_word[pcc_pkg::BIT_IO_SPACE]      = io_space_control;
   end

   assign class_word = {pcc_pkg::BASE_CLASS_CODE, pcc_pkg::SUBCLASS_CODE,
                        8'h00, REVISION_NUMBER, STEP_NUMBER};                     // [RQ8] [RQ9]

   // Read mux, one hit per address.
   always_comb
   begin
      next_prdata  = pcc_pkg::ZERO_WORD;
      next_pslverr = 1'b0;
      if (paddr == pcc_pkg::ADDR_COMMAND)
      begin
         next_prdata = command_word;
      end
      else if (paddr == pcc_pkg::ADDR_CLASS_REV)
      begin
         next_prdata  = class_word;
         next_pslverr = pwrite;  // Read-only word refuses writes.
      end
      else if (paddr == pcc_pkg::ADDR_IRQ_STATUS)
      begin
         next_prdata[pcc_pkg::IRQ_WIDTH-1:0] = irq_status;
      end
      else if (paddr == pcc_pkg::ADDR_IRQ_MASK)
      begin
         next_prdata[pcc_pkg::IRQ_WIDTH-1:0] = irq_mask;
      end
      else if (paddr == pcc_pkg::ADDR_EVENT_COUNT)
      begin
         next_prdata[15:0] = event_count;
      end
      else
      begin
         next_pslverr = ~addr_mapped;
      end
      if (!pwrite)
      begin
         next_pslverr = ~addr_mapped;
      end
   end

   // ---------------------------------------------------------------
   // APB answer registers.
   // ---------------------------------------------------------------

   // Answer flops: pready pulses one cycle in the access phase.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= pcc_pkg::ZERO_WORD;
      end
      else
      begin
         pready  <= setup_phase;
         pslverr <= setup_phase & next_pslverr;
         prdata  <= setup_phase ? next_prdata : pcc_pkg::ZERO_WORD;
      end
   end

   // ---------------------------------------------------------------
   // Command register.
   // ---------------------------------------------------------------

   // Only the low byte lane and lane one hold writable bits; all other
   // positions are dropped on the floor.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         io_space_control       <= pcc_pkg::RST_IO_SPACE;                         // [RQ7]
         memory_space_enable    <= pcc_pkg::RST_MEM_SPACE;                        // [RQ6]
         bus_master_enable      <= pcc_pkg::RST_BUS_MASTER;                       // [RQ5]
         parity_response_enable <= pcc_pkg::RST_PARITY_RESP;                      // [RQ3]
         syserr_response_enable <= pcc_pkg::RST_SYSERR_RESP;                      // [RQ2]
      end
      else if (wr_strobe && paddr == pcc_pkg::ADDR_COMMAND)
      begin
         if (pstrb[0])
         begin
            io_space_control       <= pwdata[pcc_pkg::BIT_IO_SPACE];              // [RQ7]
            memory_space_enable    <= pwdata[pcc_pkg::BIT_MEM_SPACE];             // [RQ6]
            bus_master_enable      <= pwdata[pcc_pkg::BIT_BUS_MASTER];            // [RQ5]
            parity_response_enable <= pwdata[pcc_pkg::BIT_PARITY_RESP];
         end
         if (pstrb[1])
         begin
            syserr_response_enable <= pwdata[pcc_pkg::BIT_SYSERR_RESP];
         end
      end
   end

   // System-error status is sticky, write one to clear; a new error in
   // the clearing cycle keeps it set.
   assign clr_syserr = wr_strobe && paddr == pcc_pkg::ADDR_COMMAND && pstrb[1]
                       && pwdata[pcc_pkg::BIT_SYSERR_STATUS];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         syserr_status <= 1'b0;
      end
      else if (any_err_taken)
      begin
         syserr_status <= 1'b1;                                                   // [RQ4]
      end
      else if (clr_syserr)
      begin
         syserr_status <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Outward enables and SERR pin.
   // ---------------------------------------------------------------

   // Registered copies so every output comes from a flop; a one-cycle
   // lag after a write is harmless for enables held by software.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enables.bus_master_enable   <= pcc_pkg::RST_BUS_MASTER;
         enables.memory_space_enable <= pcc_pkg::RST_MEM_SPACE;
         enables.io_space_enable     <= ~pcc_pkg::RST_IO_SPACE;
      end
      else
      begin
         enables.bus_master_enable   <= bus_master_enable;                        // [RQ5]
         enables.memory_space_enable <= memory_space_enable;                      // [RQ6]
         enables.io_space_enable     <= ~io_space_control;                        // [RQ7]
      end
   end

   // SERR is open drain: driven low for one cycle per address error.
   // A data parity error never reaches the pin; it shows only in status, the event count and the interrupt.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         serr_n_oe  <= 1'b0;
         serr_n_out <= 1'b1;
      end
      else
      begin
         serr_n_oe  <= addr_err_taken & syserr_response_enable;                   // [RQ2]
         serr_n_out <= ~(addr_err_taken & syserr_response_enable);                // [RQ2]
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status, mask and event counter.
   // ---------------------------------------------------------------

   // Set wins over a write-one clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status <= '0;
      end
      else if (wr_strobe && paddr == pcc_pkg::ADDR_IRQ_STATUS && pstrb[0])
      begin
         irq_status <= (irq_status & ~pwdata[pcc_pkg::IRQ_WIDTH-1:0]) | irq_events;
      end
      else
      begin
         irq_status <= irq_status | irq_events;
      end
   end

   // Mask resets to all zero so no interrupt fires before software has
   // chosen which events it wants to hear about.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_mask <= '0;
      end
      else if (wr_strobe && paddr == pcc_pkg::ADDR_IRQ_MASK && pstrb[0])
      begin
         irq_mask <= pwdata[pcc_pkg::IRQ_WIDTH-1:0];
      end
   end

   // Counter saturates rather than wraps so software never sees a
   // small count after a storm of errors.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         event_count <= 16'h0000;
      end
      else if (any_err_taken && event_count != COUNT_MAX)
      begin
         event_count <= event_count + 16'h0001;
      end
   end

   // Level interrupt from a flop, so it lags the status by one cycle and
   // carries no glitch from the status and mask logic.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(irq_status & irq_mask);
      end
   end

endmodule : pcc_config_regs

// ---- hw/pcc_pkg.sv ----
package pcc_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses on the APB side).
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_COMMAND     = 8'h04;
   localparam logic [7:0] ADDR_CLASS_REV   = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h40;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h44;
   localparam logic [7:0] ADDR_EVENT_COUNT = 8'h48;

   // ---------------------------------------------------------------
   // Command register field positions.
   // ---------------------------------------------------------------
   localparam int BIT_IO_SPACE      = 0;
   localparam int BIT_MEM_SPACE     = 1;
   localparam int BIT_BUS_MASTER    = 2;
   localparam int BIT_PARITY_RESP   = 6;
   localparam int BIT_SYSERR_RESP   = 8;
   localparam int BIT_SYSERR_STATUS = 13;
   localparam int BIT_NEW_CAPS      = 20;
   localparam int BIT_PM_CAPS       = 19;

   // Reset values of the writable command bits.
   localparam logic RST_IO_SPACE    = 1'b1;
   localparam logic RST_MEM_SPACE   = 1'b1;
   localparam logic RST_BUS_MASTER  = 1'b1;
   localparam logic RST_PARITY_RESP = 1'b0;
   localparam logic RST_SYSERR_RESP = 1'b1;

   // Class code fields.
   localparam logic [7:0] BASE_CLASS_CODE = 8'h02;
   localparam logic [7:0] SUBCLASS_CODE   = 8'h00;

   // Interrupt status bit positions.
   localparam int IRQ_ADDR_PARITY = 0;
   localparam int IRQ_DATA_PARITY = 1;
   localparam int IRQ_WIDTH       = 2;

   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   // Grouped parity event inputs.
   typedef struct packed {
      logic addr_parity_error;
      logic data_parity_error;
   } pcc_parity_type;

   // Grouped command enables that steer the rest of the controller.
   typedef struct packed {
      logic bus_master_enable;
      logic memory_space_enable;
      logic io_space_enable;
   } pcc_enables_type;

endpackage : pcc_pkg

// ---- tb/pcc_config_regs_asserts.sv ----
module pcc_config_regs_asserts (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [7:0]              paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [3:0]              pstrb,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic [31:0]             power_mgmt_control_reg,
   input wire pcc_pkg::pcc_parity_type parity_in,
   input wire pcc_pkg::pcc_enables_type enables,
   input wire logic                    serr_n_out,
   input wire logic                    serr_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Shadow of the two response enables, which have no port.
   // ---------------------------------------------------------------
   logic par_en;
   logic se_en;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Only completed writes to the command word move the shadow.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         par_en <= 1'b0;
         se_en  <= 1'b1;
      end
      else if (psel && penable && pready && pwrite && paddr == pcc_pkg::ADDR_COMMAND)
      begin
         if (pstrb[0]) par_en <= pwdata[6];
         if (pstrb[1]) se_en <= pwdata[8];
      end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done(logic w, logic [7:0] a);
      psel && penable && pready && pwrite == w && paddr == a;
   endsequence
   property p_pready_pulse;
      s_setup |=> pready ##1 !pready;
   endproperty
   // Enables pass two flops after the write edge: the field, then the port.
   property p_bus_master;
      s_done(1'b1, pcc_pkg::ADDR_COMMAND) ##0 pstrb[0]
         |-> ##2 enables.bus_master_enable == $past(pwdata[2], 2);
   endproperty
   property p_mem_space;
      s_done(1'b1, pcc_pkg::ADDR_COMMAND) ##0 pstrb[0]
         |-> ##2 enables.memory_space_enable == $past(pwdata[1], 2);
   endproperty
   property p_io_space;
      s_done(1'b1, pcc_pkg::ADDR_COMMAND) ##0 pstrb[0]
         |-> ##2 enables.io_space_enable == !$past(pwdata[0], 2);
   endproperty
   property p_serr_on;
      parity_in.addr_parity_error && par_en && se_en |=> serr_n_oe && !serr_n_out;
   endproperty
   property p_serr_cause;
      serr_n_oe |-> $past(parity_in.addr_parity_error && par_en && se_en);
   endproperty
   property p_new_caps;
      s_done(1'b0, pcc_pkg::ADDR_COMMAND) |-> prdata[20] == power_mgmt_control_reg[19];
   endproperty
   property p_reserved;
      s_done(1'b0, pcc_pkg::ADDR_COMMAND) |-> prdata[19:14] == 6'h00 && prdata[12:9] == 4'h0
         && !prdata[7] && prdata[5:3] == 3'h0;
   endproperty
   property p_class;
      s_done(1'b0, pcc_pkg::ADDR_CLASS_REV) |-> prdata[31:8] == {pcc_pkg::BASE_CLASS_CODE,
         pcc_pkg::SUBCLASS_CODE, 8'h00};
   endproperty
   property p_class_ro;
      s_done(1'b1, pcc_pkg::ADDR_CLASS_REV) |-> pslverr;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("pready not a single pulse");
   a_bus_master: assert property (p_bus_master) else $error("bus master enable wrong");
   a_mem_space: assert property (p_mem_space) else $error("memory enable wrong");
   a_io_space: assert property (p_io_space) else $error("io enable wrong");
   a_serr_on: assert property (p_serr_on) else $error("serr missing");
   a_serr_cause: assert property (p_serr_cause) else $error("serr without cause");
   a_new_caps: assert property (p_new_caps) else $error("caps flag wrong");
   a_reserved: assert property (p_reserved) else $error("reserved bit set");
   a_class: assert property (p_class) else $error("class code wrong");
   a_class_ro: assert property (p_class_ro) else $error("class write accepted");
endmodule : pcc_config_regs_asserts

bind pcc_config_regs pcc_config_regs_asserts u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .power_mgmt_control_reg(power_mgmt_control_reg), .parity_in(parity_in),
   .enables(enables), .serr_n_out(serr_n_out), .serr_n_oe(serr_n_oe));

// ---- tb/pcc_pci_host.sv ----
module pcc_pci_host (
   input  wire logic               pclk,
   input  wire logic               serr_n_out,
   input  wire logic               serr_n_oe,
   output pcc_pkg::pcc_parity_type parity,
   output logic [31:0]             pm_ctrl,
   output logic                    serr_wire,
   output int                      serr_lows
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Open-drain line with its pull-up; released means high.
   // ---------------------------------------------------------------
   assign serr_wire = serr_n_oe ? serr_n_out : 1'b1;
   initial
   begin
      parity    = '0;
      pm_ctrl   = 32'h0000_0000;
      serr_lows = 0;
   end
   // Counting low cycles catches a pulse that is too long as well.
   always @(posedge pclk)
      if (!serr_wire) serr_lows <= serr_lows + 1;
   // One-cycle error pulse, as the bus checker reports it.
   task pulse(input logic a, input logic d);
      @(posedge pclk);
      parity <= '{a, d};
      @(posedge pclk);
      parity <= '0;
   endtask : pulse
   task set_pm(input logic [31:0] v);
      @(posedge pclk);
      pm_ctrl <= v;
   endtask : set_pm
endmodule : pcc_pci_host

// ---- tb/pci_config_command_class_tb.sv ----
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module pci_config_command_class_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] REV  = 4'h5;  // Arbitrary value.
   localparam logic [3:0] STEP = 4'h3;  // Arbitrary value.
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, so, soe, sw;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, pm, rd, d, r;
   logic [31:0] seed = 32'h0000_0054;
   logic [3:0]  pstrb, s;
   logic        er, b0, b1, b2, b6, b8, st13;
   int          num_errors, check_count, i, lows;
   pcc_pkg::pcc_parity_type par;
   pcc_pkg::pcc_enables_type en;
   pcc_config_regs #(.REVISION_NUMBER(REV), .STEP_NUMBER(STEP)) DUT (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_mgmt_control_reg(pm), .parity_in(par), .enables(en), .serr_n_out(so),
      .serr_n_oe(soe), .irq(irq));
   pcc_pci_host host (.pclk(pclk), .serr_n_out(so), .serr_n_oe(soe), .parity(par),
      .pm_ctrl(pm), .serr_wire(sw), .serr_lows(lows));
   // ---------------------------------------------------------------
   // Helpers.
   // ---------------------------------------------------------------
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Expected command bits 20 to 0 from the bench's own shadow bits and pm.
   function logic [31:0] exp_cmd();
      return {11'h000, pm[19], 6'h00, st13, 4'h0, b8, 1'b0, b6, 3'h0, b2, b1, b0};
   endfunction : exp_cmd
   task conclude();
      if (num_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] st);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (n >= 16)
      begin
         num_errors++;
         conclude();
      end
      else
      begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb
   task rd_cmd();
      apb(1'b0, pcc_pkg::ADDR_COMMAND, 32'h0000_0000, 4'h0);
      `CHK("command", exp_cmd(), rd & 32'h001F_FFFF)
   endtask : rd_cmd
   // ---------------------------------------------------------------
   // Clock, watchdog and main sequence.
   // ---------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // A hang is cut short here and counted.
   initial
   begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      conclude();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {b0, b1, b2, b6, b8, st13} = 6'b111010;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("reset enables", 3'b110, en)
      rd_cmd();
      // Corner words first, then random words and strobes.
      for (i = 0; i < 18; i++)
      begin
         r = rnd();
         d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : rnd();
         s = (i < 2) ? 4'hF : r[3:0];
         host.set_pm(r);
         apb(1'b1, pcc_pkg::ADDR_COMMAND, d & 32'hFFFF_DFFF, s);
         if (s[0]) {b6, b2, b1, b0} = {d[6], d[2], d[1], d[0]};
         if (s[1]) b8 = d[8];
         rd_cmd();
         `CHK("enables", {b2, b1, !b0}, en)
      end
      // Address parity with both responses on.
      apb(1'b1, pcc_pkg::ADDR_COMMAND, 32'h0000_0147, 4'hF);
      {b6, b8, b2, b1, b0} = 5'b11111;
      apb(1'b1, pcc_pkg::ADDR_IRQ_MASK, 32'h0000_0003, 4'hF);
      host.pulse(1'b1, 1'b0);
      repeat (3) @(posedge pclk);
      `CHK("irq set", 1'b1, irq)
      `CHK("serr pulse", 1, lows)
      st13 = 1'b1;
      rd_cmd();
      apb(1'b0, pcc_pkg::ADDR_IRQ_STATUS, 32'h0000_0000, 4'h0);
      `CHK("irq status", 32'h0000_0001, rd)
      apb(1'b0, pcc_pkg::ADDR_EVENT_COUNT, 32'h0000_0000, 4'h0);
      `CHK("count", 16'h0001, rd[15:0])
      apb(1'b1, pcc_pkg::ADDR_COMMAND, 32'h0000_2100, 4'h2);
      apb(1'b1, pcc_pkg::ADDR_IRQ_STATUS, 32'h0000_0001, 4'hF);
      st13 = 1'b0;
      repeat (2) @(posedge pclk);
      `CHK("irq clear", 1'b0, irq)
      rd_cmd();
      // A data parity error sets status and interrupt but not the pin.
      host.pulse(1'b0, 1'b1);
      repeat (3) @(posedge pclk);
      `CHK("serr data only", 1, lows)
      `CHK("irq data", 1'b1, irq)
      st13 = 1'b1;
      rd_cmd();
      apb(1'b0, pcc_pkg::ADDR_IRQ_STATUS, 32'h0000_0000, 4'h0);
      `CHK("irq data status", 32'h0000_0002, rd)
      apb(1'b1, pcc_pkg::ADDR_IRQ_STATUS, 32'h0000_0002, 4'hF);
      // Parity response off: every error is ignored.
      apb(1'b1, pcc_pkg::ADDR_COMMAND, 32'h0000_0107, 4'hF);
      b6 = 1'b0;
      host.pulse(1'b1, 1'b1);
      repeat (3) @(posedge pclk);
      `CHK("irq ignored", 1'b0, irq)
      `CHK("serr ignored", 1, lows)
      apb(1'b0, pcc_pkg::ADDR_EVENT_COUNT, 32'h0000_0000, 4'h0);
      `CHK("count ignored", 16'h0002, rd[15:0])
      rd_cmd();
      // Class word, its refused write, and an unmapped place.
      for (i = 0; i < 2; i++)
      begin
         apb(1'b1, pcc_pkg::ADDR_CLASS_REV, 32'hFFFF_FFFF, 4'hF);
         `CHK("class write err", 1'b1, er)
         apb(1'b0, pcc_pkg::ADDR_CLASS_REV, 32'h0000_0000, 4'h0);
         d = {pcc_pkg::BASE_CLASS_CODE, pcc_pkg::SUBCLASS_CODE, 8'h00, REV, STEP};
         `CHK("class", d, rd)
      end
      apb(1'b0, 8'h20, 32'h0000_0000, 4'h0);
      `CHK("unmapped err", 1'b1, er)
      conclude();
   end
endmodule : pci_config_command_class_tb
